// ==== common/ext_req_if.sv ====
// Request and answer bundle between the sequencer and the bus engine.
`timescale 1ns/10ps
`include "sys_consts.svh"
interface ext_req_if;
    import sys_pkg::*;
    logic valid;
    logic ready;
    logic write;
    space_type space;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic done;
    logic [`DATA_W-1:0] rdata;
    modport requester (output valid, output write, output space, output addr, output wdata,
        input ready, input done, input rdata);
    modport engine (input valid, input write, input space, input addr, input wdata,
        output ready, output done, output rdata);
endinterface

// ==== common/sys_consts.svh ====
// Constants for the reset sequencer and external memory bus pins.
`ifndef SYS_CONSTS_SVH
`define SYS_CONSTS_SVH

`define ADDR_W 14
`define DATA_W 24
`define BOOT_HI_LSB 22
`define WAIT_W 3
`define WAIT_RESET 3'h7
`define LOCK_PERIODS 2000
`define LOCK_CYCLES (`LOCK_PERIODS * 1)
`define LOCK_CNT_W 11
`define SYNC_W 14
`define SYNC_RESET 14'h3FFF
`define LIMIT_W 15
`define PM_WORDS_FULL 15'h4000
`define DM_WORDS_FULL 15'h3C00
`define PM_WORDS_REDUCED 15'h3C00
`define DM_WORDS_REDUCED 15'h3A00
`define ONCHIP_PM_FULL 14'h0800
`define ONCHIP_PM_REDUCED 14'h0400
`define ONCHIP_PM_HI_BASE 14'h3800
`define START_PC 14'h0000

`endif

// ==== common/sys_pkg.sv ====
// Types shared by the reset sequencer and the external bus engine.
package sys_pkg;
    typedef enum logic [1:0] {
        SPACE_PM = 2'b00,
        SPACE_DM = 2'b01,
        SPACE_BOOT = 2'b10
    } space_type;
    typedef enum logic [1:0] {
        RS_LOCK = 2'b00,
        RS_HOLD = 2'b01,
        RS_BOOT = 2'b10,
        RS_RUN = 2'b11
    } reset_state_type;
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACTIVE = 1'b1
    } bus_state_type;
    typedef struct packed {
        logic tfs;
        logic rfs;
        logic dt;
        logic dr;
        logic sclk;
    } sport_pins_type;
endpackage

// ==== hw/ext_bus_cycle.sv ====
// External memory bus cycle engine with programmable wait states.
`timescale 1ns/10ps
`include "sys_consts.svh"
module ext_bus_cycle
    import sys_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [`WAIT_W-1:0] wait_states,
    input wire logic granted,
    ext_req_if.engine req,
    input wire logic [`DATA_W-1:0] data_in,
    output logic idle,
    output logic [`ADDR_W-1:0] addr_q,
    output logic [`DATA_W-1:0] dout_q,
    output logic [`DATA_W-1:0] doe_q,
    output logic pm_sel_n_q,
    output logic dm_sel_n_q,
    output logic bm_sel_n_q,
    output logic rd_n_q,
    output logic wr_n_q
);
    bus_state_type state_q;
    logic [`WAIT_W-1:0] count_q;
    logic [`WAIT_W-1:0] wait_l_q;
    logic [`WAIT_W:0] len_q;
    wire take = req.valid && req.ready;
    wire last = (state_q == BUS_ACTIVE) && (count_q == 3'h0);
    wire is_boot = req.space == SPACE_BOOT;
    wire do_write = req.write && !is_boot;
    wire [`DATA_W-1:0] drive_d = is_boot ? {2'h3, 22'h000000} : {`DATA_W{do_write}};
    wire strobe_on = !rd_n_q || !wr_n_q;

    assign req.ready = (state_q == BUS_IDLE) && !granted;
    assign req.done = last;
    assign req.rdata = data_in;
    assign idle = state_q == BUS_IDLE;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= BUS_IDLE;
            count_q <= 3'h0;
            addr_q <= 14'h0000;
            dout_q <= 24'h000000;
            doe_q <= 24'h000000;
            pm_sel_n_q <= 1'b1;
            dm_sel_n_q <= 1'b1;
            bm_sel_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else if (take) begin
            state_q <= BUS_ACTIVE;
            count_q <= wait_states;
            addr_q <= req.addr;
            dout_q <= req.wdata;
            doe_q <= drive_d;
            pm_sel_n_q <= req.space != SPACE_PM;
            dm_sel_n_q <= req.space != SPACE_DM;
            bm_sel_n_q <= !is_boot;
            rd_n_q <= do_write;
            wr_n_q <= !do_write;
        end else if (last) begin
            state_q <= BUS_IDLE;
            doe_q <= 24'h000000;
            pm_sel_n_q <= 1'b1;
            dm_sel_n_q <= 1'b1;
            bm_sel_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else if (state_q == BUS_ACTIVE) begin
            count_q <= count_q - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_l_q <= 3'h0;
            len_q <= 4'h0;
        end else begin
            if (take) begin
                wait_l_q <= wait_states;
            end
            len_q <= strobe_on ? len_q + 4'h1 : 4'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_strobe_end;
        $fell(strobe_on) ##0 1'b1;
    endsequence

    a_strobe_width: assert property (s_strobe_end |-> len_q == {1'b0, wait_l_q} + 4'h1)
        else $error("Strobe width is off.");
    a_one_select: assert property ($onehot0({!pm_sel_n_q, !dm_sel_n_q, !bm_sel_n_q}))
        else $error("Two selects active.");
    a_boot_no_write: assert property (!bm_sel_n_q |-> wr_n_q && doe_q[21:0] == 22'h000000)
        else $error("Boot access drives data.");
    a_strobe_pair: assert property (!(!rd_n_q && !wr_n_q))
        else $error("Both strobes active.");
endmodule

// ==== hw/system_reset_and_bus_pins.sv ====
// Reset sequencing, clock output, shared pin routing and external bus front end.
`timescale 1ns/10ps
`include "sys_consts.svh"
// What this block does
// - A low reset pin returns the whole processor to its initial state.
// - Warm reset with unchanged clock skips the lock wait.
// - A clock output follows the internal instruction cycles.
// - One 14-bit address bus serves program, data and boot memory.
// - 24-bit data bus is two-way; boot reads use it as input, top bits give page.
// - Separate active-low selects mark program, data and boot accesses.
// - Separate active-low read and write strobes time external transfers.
// - A low bus request is answered by a low bus grant.
// - The memory map select input lays out on-chip and off-chip program memory.
// - Two-port parts: one interrupt with both ports, or three with port zero.
// - One-port part: one interrupt with port one, or three and no port.
// - Port one receive frame sync becomes interrupt zero, transmit sync interrupt one.
// - Each serial port has five pins: both frame syncs, both data lines, clock.
// - External accesses insert a programmable number of wait states.
// - Full parts address 15K data words and 16K program words.
// - Reduced parts address 14.5K data words and 15K program words.
// - Wait states range from 0 to 7 and are 7 after reset.
// - After reset, boot if configured, then fetch from program address 0x0000.
module system_reset_and_bus_pins
    import sys_pkg::*;
#(
    parameter bit TWO_SPORTS = 1'b1,
    parameter bit FULL_MEMORY = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic memory_map_select,
    input wire logic bus_request_n,
    output logic bus_grant_n,
    output logic processor_clock_out,
    output logic [`ADDR_W-1:0] address_out,
    input wire logic [`DATA_W-1:0] data_in,
    output logic [`DATA_W-1:0] data_out,
    output logic [`DATA_W-1:0] data_oe,
    output logic prog_mem_select_n,
    output logic data_mem_select_n,
    output logic boot_mem_select_n,
    output logic read_n,
    output logic write_n,
    output logic control_oe,
    input wire logic ext_irq_two_pin_n,
    input wire sport_pins_type serial_port_zero_pin,
    input wire sport_pins_type serial_port_one_pin,
    input wire logic sport_one_as_irq,
    output logic ext_irq_two_n,
    output logic ext_irq_one_n,
    output logic ext_irq_zero_n,
    output sport_pins_type serial_port_zero,
    output sport_pins_type serial_port_one,
    output logic core_reset,
    output logic boot_start,
    input wire logic boot_done,
    output logic fetch_start,
    output logic [`ADDR_W-1:0] start_address,
    input wire logic wait_load,
    input wire logic [`WAIT_W-1:0] wait_value,
    output logic [`WAIT_W-1:0] wait_states,
    input wire logic core_req_valid,
    input wire logic core_req_write,
    input wire space_type core_req_space,
    input wire logic [`ADDR_W-1:0] core_req_addr,
    input wire logic [`DATA_W-1:0] core_req_wdata,
    output logic core_req_ready,
    output logic core_rsp_valid,
    output logic [`DATA_W-1:0] core_rsp_rdata,
    output logic core_rsp_onchip,
    output logic core_rsp_error
);
    logic [`SYNC_W-1:0] sync1_q;
    logic [`SYNC_W-1:0] sync2_q;
    reset_state_type state_q;
    reset_state_type state_d;
    logic [`LOCK_CNT_W-1:0] lock_cnt_q;
    logic core_reset_q;
    logic boot_start_q;
    logic fetch_start_q;
    logic [`WAIT_W-1:0] wait_q;
    logic processor_clock_out_q;
    logic grant_q;
    logic rsp_valid_q;
    logic [`DATA_W-1:0] rsp_rdata_q;
    logic rsp_onchip_q;
    logic rsp_error_q;
    logic eng_idle;
    sport_pins_type sport_zero_q;
    sport_pins_type sport_one_q;
    logic irq_two_q;
    logic irq_one_q;
    logic irq_zero_q;
    ext_req_if req ();

    // Reset, map select, bus request, interrupt two and serial port pins pass two flip-flops before any logic reads them.
    wire [`SYNC_W-1:0] pins_raw = {reset_pin_n, memory_map_select, bus_request_n,
        ext_irq_two_pin_n, serial_port_zero_pin, serial_port_one_pin};
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= `SYNC_RESET;
            sync2_q <= `SYNC_RESET;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    wire rs_pin_s = sync2_q[13];
    wire memory_map_select_s = sync2_q[12];
    wire br_n_s = sync2_q[11];
    wire ext_irq_two_n_s = sync2_q[10];
    wire sport_pins_type sp0_s = sync2_q[9:5];
    wire sport_pins_type sp1_s = sync2_q[4:0];

    // Reset sequencer: lock wait only after power-on, warm resets skip it.
    wire lock_done = lock_cnt_q == `LOCK_CNT_W'(`LOCK_CYCLES - 1);
    wire boot_wanted = !memory_map_select_s;
    always_comb begin
        state_d = state_q;
        case (state_q)
            RS_LOCK: begin
                if (lock_done) begin
                    state_d = RS_HOLD;
                end
            end
            RS_HOLD: begin
                if (rs_pin_s && !boot_wanted) begin
                    state_d = RS_RUN;
                end else if (rs_pin_s && br_n_s) begin
                    state_d = RS_BOOT;
                end
            end
            RS_BOOT: begin
                if (!rs_pin_s) begin
                    state_d = RS_HOLD;
                end else if (boot_done) begin
                    state_d = RS_RUN;
                end
            end
            RS_RUN: begin
                if (!rs_pin_s) begin
                    state_d = RS_HOLD;
                end
            end
            default: begin
                state_d = RS_LOCK;
            end
        endcase
    end

    wire in_reset_d = (state_d == RS_LOCK) || (state_d == RS_HOLD);
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= RS_LOCK;
            lock_cnt_q <= 11'h000;
            core_reset_q <= 1'b1;
            boot_start_q <= 1'b0;
            fetch_start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            lock_cnt_q <= (state_q == RS_LOCK) ? lock_cnt_q + 11'h001 : lock_cnt_q;
            core_reset_q <= in_reset_d;
            boot_start_q <= (state_q == RS_HOLD) && (state_d == RS_BOOT);
            fetch_start_q <= (state_q != RS_RUN) && (state_d == RS_RUN);
        end
    end

    // Wait-state count, back to its maximum on every reset.
    always_ff @(posedge clk) begin
        if (rst || core_reset_q) begin
            wait_q <= `WAIT_RESET;
        end else if (wait_load) begin
            wait_q <= wait_value;
        end
    end

    // Clock output toggles on every internal cycle edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            processor_clock_out_q <= 1'b0;
        end else begin
            processor_clock_out_q <= !processor_clock_out_q;
        end
    end

    // Bus grant once the engine has no cycle in flight.
    always_ff @(posedge clk) begin
        if (rst) begin
            grant_q <= 1'b0;
        end else if (br_n_s) begin
            grant_q <= 1'b0;
        end else if (eng_idle) begin
            grant_q <= 1'b1;
        end
    end

    // Serial port one yields its frame syncs to interrupts zero and one.
    wire sport_zero_on = TWO_SPORTS;
    wire sport_one_on = !sport_one_as_irq;
    always_ff @(posedge clk) begin
        if (rst) begin
            sport_zero_q <= 5'h1F;
            sport_one_q <= 5'h1F;
            irq_two_q <= 1'b1;
            irq_one_q <= 1'b1;
            irq_zero_q <= 1'b1;
        end else begin
            sport_zero_q <= sport_zero_on ? sp0_s : 5'h1F;
            sport_one_q <= sport_one_on ? sp1_s : 5'h1F;
            irq_two_q <= ext_irq_two_n_s;
            irq_one_q <= sport_one_as_irq ? sp1_s.tfs : 1'b1;
            irq_zero_q <= sport_one_as_irq ? sp1_s.rfs : 1'b1;
        end
    end

    // Address decode: limits per variant and on-chip placement per memory map.
    wire [`LIMIT_W-1:0] pm_limit = FULL_MEMORY ? `PM_WORDS_FULL : `PM_WORDS_REDUCED;
    wire [`LIMIT_W-1:0] dm_limit = FULL_MEMORY ? `DM_WORDS_FULL : `DM_WORDS_REDUCED;
    wire [`ADDR_W-1:0] onchip_size = FULL_MEMORY ? `ONCHIP_PM_FULL : `ONCHIP_PM_REDUCED;
    wire [`LIMIT_W-1:0] addr_wide = {1'b0, core_req_addr};
    wire is_pm = core_req_space == SPACE_PM;
    wire is_dm = core_req_space == SPACE_DM;
    wire out_of_range = (is_pm && addr_wide >= pm_limit) || (is_dm && addr_wide >= dm_limit);
    wire pm_onchip = is_pm && (memory_map_select_s ? core_req_addr >= `ONCHIP_PM_HI_BASE
        : core_req_addr < onchip_size);
    wire accepting = (state_q == RS_BOOT) || (state_q == RS_RUN);
    wire local_hit = out_of_range || pm_onchip;
    wire local_take = core_req_valid && core_req_ready && local_hit;

    assign core_req_ready = accepting && req.ready;
    assign req.valid = core_req_valid && accepting && !local_hit;
    assign req.write = core_req_write;
    assign req.space = core_req_space;
    assign req.addr = core_req_addr;
    assign req.wdata = core_req_wdata;

    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 24'h000000;
            rsp_onchip_q <= 1'b0;
            rsp_error_q <= 1'b0;
        end else begin
            rsp_valid_q <= local_take || req.done;
            rsp_rdata_q <= req.done ? req.rdata : 24'h000000;
            rsp_onchip_q <= local_take && pm_onchip && !out_of_range;
            rsp_error_q <= local_take && out_of_range;
        end
    end

    wire hold_off = grant_q || !br_n_s;
    ext_bus_cycle engine (
        .clk(clk),
        .rst(rst),
        .wait_states(wait_q),
        .granted(hold_off),
        .req(req),
        .data_in(data_in),
        .idle(eng_idle),
        .addr_q(address_out),
        .dout_q(data_out),
        .doe_q(data_oe),
        .pm_sel_n_q(prog_mem_select_n),
        .dm_sel_n_q(data_mem_select_n),
        .bm_sel_n_q(boot_mem_select_n),
        .rd_n_q(read_n),
        .wr_n_q(write_n)
    );

    assign bus_grant_n = !grant_q;
    assign control_oe = !grant_q;
    assign processor_clock_out = processor_clock_out_q;
    assign ext_irq_two_n = irq_two_q;
    assign ext_irq_one_n = irq_one_q;
    assign ext_irq_zero_n = irq_zero_q;
    assign serial_port_zero = sport_zero_q;
    assign serial_port_one = sport_one_q;
    assign core_reset = core_reset_q;
    assign boot_start = boot_start_q;
    assign fetch_start = fetch_start_q;
    assign start_address = `START_PC;
    assign wait_states = wait_q;
    assign core_rsp_valid = rsp_valid_q;
    assign core_rsp_rdata = rsp_rdata_q;
    assign core_rsp_onchip = rsp_onchip_q;
    assign core_rsp_error = rsp_error_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_warm_reset;
        state_q == RS_RUN ##0 !rs_pin_s;
    endsequence

    a_warm_core_reset: assert property (s_warm_reset |=> core_reset && state_q == RS_HOLD)
        else $error("Warm reset missed.");
    a_lock_wait: assert property (state_q == RS_LOCK && !lock_done |=> state_q == RS_LOCK)
        else $error("Lock wait cut short.");
    a_no_relock: assert property (state_q != RS_LOCK |=> state_q != RS_LOCK)
        else $error("Lock wait repeated.");
    a_processor_clock_out_toggle: assert property (!$past(rst) |-> processor_clock_out_q != $past(processor_clock_out_q))
        else $error("Clock out stuck.");
    a_wait_after_reset: assert property ($fell(core_reset) |-> wait_states == `WAIT_RESET)
        else $error("Wait count not 7.");
    a_grant_floats: assert property (!bus_grant_n |-> !control_oe && data_oe == 24'h000000)
        else $error("Pins driven while granted.");
    a_irq_routing: assert property (sport_one_as_irq |=> ext_irq_zero_n == $past(sp1_s.rfs))
        else $error("Irq zero misrouted.");
    a_range_guard: assert property (!data_mem_select_n |-> {1'b0, address_out} < dm_limit)
        else $error("Data address beyond range.");
    a_boot_to_fetch: assert property (state_q == RS_BOOT && rs_pin_s && boot_done
        |=> fetch_start ##1 !fetch_start)
        else $error("No fetch after boot.");
endmodule

// ==== verification/ext_mem_model.sv ====
// Behavioural external program, data and boot memory on the shared bus.
`timescale 1ns/10ps
`include "sys_consts.svh"
module ext_mem_model (
    input wire logic clk,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic pm_n,
    input wire logic dm_n,
    input wire logic bm_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [`DATA_W-1:0] bus,
    output logic [`DATA_W-1:0] drive,
    output logic [`ADDR_W-1:0] wr_addr,
    output logic [`DATA_W-1:0] wr_data
);
    logic [1:0] code;
    logic [`DATA_W-1:0] last_q;
    // Top bits name the selected space.
    assign code = !pm_n ? 2'h1 : (!dm_n ? 2'h2 : (!bm_n ? 2'h3 : 2'h0));
    // A released bus shows the inverse of the last word read.
    assign drive = (!rd_n && code != 2'h0) ? {code, 8'hA5, addr} : ~last_q;
    initial begin
        last_q = 24'h000000;
        wr_addr = 14'h0000;
        wr_data = 24'h000000;
    end
    always @(posedge clk) begin
        if (!rd_n && code != 2'h0) begin
            last_q <= drive;
        end
        if (!wr_n && code != 2'h0) begin
            wr_addr <= addr;
            wr_data <= bus;
        end
    end
endmodule

// ==== verification/system_reset_and_bus_pins_tb.sv ====
// Self-checking bench for the reset sequencer and external bus pins.
`timescale 1ns/10ps
`include "sys_consts.svh"
module system_reset_and_bus_pins_tb;
    import sys_pkg::*;
    logic clk, rst, reset_pin_n, memory_map_select, bus_request_n, bus_grant_n;
    logic processor_clock_out, prog_mem_select_n, data_mem_select_n, boot_mem_select_n;
    logic read_n, write_n, control_oe, ext_irq_two_pin_n, sport_one_as_irq;
    logic ext_irq_two_n, ext_irq_one_n, ext_irq_zero_n, core_reset, boot_start, boot_done;
    logic fetch_start, wait_load, core_req_valid, core_req_write, core_req_ready;
    logic core_rsp_valid, core_rsp_onchip, core_rsp_error;
    logic [`ADDR_W-1:0] address_out, start_address, core_req_addr, wr_addr;
    logic [`DATA_W-1:0] data_in, data_out, data_oe, mem_drive, wr_data;
    logic [`DATA_W-1:0] core_req_wdata, core_rsp_rdata, s_oe, s_out;
    logic [`WAIT_W-1:0] wait_value, wait_states;
    sport_pins_type serial_port_zero_pin, serial_port_one_pin;
    sport_pins_type serial_port_zero, serial_port_one;
    space_type core_req_space;
    int bad_count = 0;
    int n_compared = 0;

    // Each data line carries the design's value where it drives, else the memory's.
    assign data_in = (data_oe & data_out) | (~data_oe & mem_drive);

    system_reset_and_bus_pins u_system_reset_and_bus_pins (
        .clk, .rst, .reset_pin_n, .memory_map_select, .bus_request_n, .bus_grant_n,
        .processor_clock_out, .address_out, .data_in, .data_out, .data_oe,
        .prog_mem_select_n, .data_mem_select_n, .boot_mem_select_n, .read_n, .write_n,
        .control_oe, .ext_irq_two_pin_n, .serial_port_zero_pin, .serial_port_one_pin,
        .sport_one_as_irq, .ext_irq_two_n, .ext_irq_one_n, .ext_irq_zero_n,
        .serial_port_zero, .serial_port_one, .core_reset, .boot_start, .boot_done,
        .fetch_start, .start_address, .wait_load, .wait_value, .wait_states,
        .core_req_valid, .core_req_write, .core_req_space, .core_req_addr, .core_req_wdata,
        .core_req_ready, .core_rsp_valid, .core_rsp_rdata, .core_rsp_onchip, .core_rsp_error
    );

    ext_mem_model u_ext_mem_model (
        .clk(clk), .addr(address_out), .pm_n(prog_mem_select_n), .dm_n(data_mem_select_n),
        .bm_n(boot_mem_select_n), .rd_n(read_n), .wr_n(write_n), .bus(data_in),
        .drive(mem_drive), .wr_addr(wr_addr), .wr_data(wr_data)
    );

    // The clock never stops or changes rate during the run.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic chkv(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // One core request with all its checks.
    task automatic run(input space_type sp, input logic wr, input logic [13:0] a,
            input logic [23:0] wd, input int ns, input logic [4:0] ctl, input logic [1:0] fl);
        int k;
        int st;
        logic [4:0] sc;
        logic [13:0] sa;
        st = 0;
        sc = 5'h1F;
        sa = 14'h0000;
        core_req_space = sp;
        core_req_write = wr;
        core_req_addr = a;
        core_req_wdata = wd;
        core_req_valid = 1'b1;
        for (k = 0; k < 50 && core_req_ready !== 1'b1; k++) step(1);
        step(1);
        core_req_valid = 1'b0;
        for (k = 0; k < 20 && core_rsp_valid !== 1'b1; k++) begin
            if (read_n === 1'b0 || write_n === 1'b0) begin
                if (st == 0) begin
                    sc = {prog_mem_select_n, data_mem_select_n, boot_mem_select_n, read_n, write_n};
                    sa = address_out;
                    s_oe = data_oe;
                    s_out = data_out;
                end
                st++;
            end
            step(1);
        end
        chk1(core_rsp_valid, 1'b1, "response");
        chkv(24'(st), 24'(ns), "strobe cycles");
        chkv(24'({core_rsp_onchip, core_rsp_error}), 24'(fl), "flags");
        if (ns > 0) begin
            chkv(24'(sc), 24'(ctl), "controls");
            chkv(24'(sa), 24'(a), "address");
            if (!wr) chkv(24'(core_rsp_rdata[21:0]), {2'h0, 8'hA5, a}, "read data");
        end
        step(1);
    endtask

    task automatic set_wait(input logic [2:0] w);
        wait_value = w;
        wait_load = 1'b1;
        step(1);
        wait_load = 1'b0;
        step(1);
        chkv(24'(wait_states), 24'(w), "wait count");
    endtask

    task automatic t_powerup();
        int k;
        step(1985);
        chk1(core_reset, 1'b1, "held during lock");
        chkv(24'(wait_states), 24'h000007, "wait after reset");
        chk1(bus_grant_n, 1'b1, "no grant at reset");
        for (k = 0; k < 60 && boot_start !== 1'b1; k++) step(1);
        chk1(boot_start, 1'b1, "boot begins");
        chkv(24'(start_address), 24'h000000, "start address");
    endtask

    task automatic t_boot();
        int k;
        run(SPACE_BOOT, 1'b0, 14'h0005, 24'h800000, 8, 5'b11001, 2'b00);
        chkv(s_oe, 24'hC00000, "boot drives top bits only");
        chkv(24'(s_out[23:22]), 24'h000002, "boot page bits");
        boot_done = 1'b1;
        step(1);
        boot_done = 1'b0;
        for (k = 0; k < 5 && fetch_start !== 1'b1; k++) step(1);
        chk1(fetch_start, 1'b1, "fetch after boot");
    endtask

    task automatic t_ext();
        set_wait(3'h0);
        run(SPACE_DM, 1'b1, 14'h0123, 24'h5A5A5A, 1, 5'b10110, 2'b00);
        chkv(s_oe, 24'hFFFFFF, "write drives bus");
        chkv(wr_data, 24'h5A5A5A, "written word");
        chkv(24'(wr_addr), 24'h000123, "written address");
        set_wait(3'h3);
        run(SPACE_PM, 1'b0, 14'h0900, 24'h000000, 4, 5'b01101, 2'b00);
        chkv(s_oe, 24'h000000, "read releases bus");
        run(SPACE_DM, 1'b0, 14'h3BFF, 24'h000000, 4, 5'b10101, 2'b00);
        run(SPACE_DM, 1'b0, 14'h3C00, 24'h000000, 0, 5'b11111, 2'b01);
        run(SPACE_PM, 1'b0, 14'h07FF, 24'h000000, 0, 5'b11111, 2'b10);
    endtask

    task automatic t_grant();
        int k;
        bus_request_n = 1'b0;
        for (k = 0; k < 8 && bus_grant_n !== 1'b0; k++) step(1);
        chk1(bus_grant_n, 1'b0, "grant");
        step(1);
        chk1(control_oe, 1'b0, "controls released");
        chkv(data_oe, 24'h000000, "data released");
        chk1(core_req_ready, 1'b0, "no access while granted");
        bus_request_n = 1'b1;
        for (k = 0; k < 8 && bus_grant_n !== 1'b1; k++) step(1);
        chk1(bus_grant_n, 1'b1, "grant withdrawn");
    endtask

    task automatic t_irq();
        sport_one_as_irq = 1'b1;
        ext_irq_two_pin_n = 1'b0;
        serial_port_zero_pin = 5'h0A;
        serial_port_one_pin = 5'h17;
        step(4);
        chk1(ext_irq_zero_n, 1'b0, "receive sync as irq zero");
        chk1(ext_irq_one_n, 1'b1, "irq one idle");
        chk1(ext_irq_two_n, 1'b0, "irq two");
        chkv(24'(serial_port_one), 24'h00001F, "port one off");
        chkv(24'(serial_port_zero), 24'h00000A, "port zero pins");
        serial_port_one_pin = 5'h0F;
        step(4);
        chk1(ext_irq_one_n, 1'b0, "transmit sync as irq one");
        chk1(ext_irq_zero_n, 1'b1, "irq zero idle");
        sport_one_as_irq = 1'b0;
        serial_port_one_pin = 5'h15;
        ext_irq_two_pin_n = 1'b1;
        step(4);
        chkv(24'(serial_port_one), 24'h000015, "port one pins");
        chk1(ext_irq_one_n, 1'b1, "no irq one with port");
        serial_port_one_pin = 5'h1F;
    endtask

    task automatic t_warm();
        int k;
        logic c0;
        logic booted = 1'b0;
        memory_map_select = 1'b1;
        reset_pin_n = 1'b0;
        step(6);
        chk1(core_reset, 1'b1, "warm reset");
        chkv(24'(wait_states), 24'h000007, "wait back to 7");
        c0 = processor_clock_out;
        step(1);
        chk1(processor_clock_out, ~c0, "clock out runs");
        reset_pin_n = 1'b1;
        for (k = 0; k < 20 && fetch_start !== 1'b1; k++) begin
            booted |= boot_start;
            step(1);
        end
        chk1(fetch_start, 1'b1, "no lock wait");
        chk1(booted, 1'b0, "no boot with map one");
        chk1(core_reset, 1'b0, "core released");
        run(SPACE_PM, 1'b0, 14'h3800, 24'h000000, 0, 5'b11111, 2'b10);
        run(SPACE_PM, 1'b0, 14'h0000, 24'h000000, 8, 5'b01101, 2'b00);
    endtask

    initial begin
        #150000;
        bad_count++;
        $display("MISMATCH at %0t: run did not finish", $time);
        end_of_test();
    end

    initial begin
        {rst, reset_pin_n, bus_request_n, ext_irq_two_pin_n} = 4'hF;
        {memory_map_select, sport_one_as_irq, boot_done, wait_load, core_req_valid} = 5'h00;
        core_req_write = 1'b0;
        core_req_space = SPACE_PM;
        core_req_addr = 14'h0000;
        core_req_wdata = 24'h000000;
        wait_value = 3'h0;
        serial_port_zero_pin = 5'h1F;
        serial_port_one_pin = 5'h1F;
        step(6);
        rst = 1'b0;
        t_powerup();
        t_boot();
        t_ext();
        t_grant();
        t_irq();
        t_warm();
        end_of_test();
    end
endmodule
